// file: rtl/slow_oscillator_control.v
// Slow oscillator control: run policy, availability, start-up and APB registers
//
// Notes on behaviour
// - With its keep-running bit at 0 the internal oscillator runs only while requested.
// - With its keep-running bit at 1 the internal oscillator runs in every mode.
// - The internal oscillator reaches a consumer only while requested and after four cycles.
// - Enabled crystal with keep-running 0 runs only on request and only in Active or Idle.
// - Enabled crystal with keep-running 1 runs in Active, Idle, Standby and Power-Down.
// - After start-up the crystal reaches a requester within three of its cycles.
// - Start-up field bits 5:4 pick 1k, 16k, 32k or 64k crystal cycles.
// - Start-up field and source select ignore writes while enabled or stable.
// - Source select bit 2 picks crystal (0) or external clock on pin a (1).
// - Bit 1 turns the crystal low-power mode on when 1.
// - The stable flag reads 1 once crystal is stable or external clock runs.
//
// Our own choice: register access over APB.
`timescale 1ns/1ns
`include "slow_osc_defines.vh"
module slow_oscillator_control #(
    parameter [16:0] SU_COUNT_0 = `XTAL_SU_1K,
    parameter [16:0] SU_COUNT_1 = `XTAL_SU_16K,
    parameter [16:0] SU_COUNT_2 = `XTAL_SU_32K,
    parameter [16:0] SU_COUNT_3 = `XTAL_SU_64K
) (
    input  wire        CLK,
    input  wire        RESET,
    input  wire        PSEL,
    input  wire        PENABLE,
    input  wire        PWRITE,
    input  wire [7:0]  PADDR,
    input  wire [31:0] PWDATA,
    output reg  [31:0] PRDATA,
    output reg         PREADY,
    output reg         PSLVERR,
    input  wire [1:0]  SLEEP_MODE,
    input  wire        INT_OSC_REQ,
    input  wire        INT_OSC_LEVEL,
    input  wire        XTAL_OSC_REQ,
    input  wire        SLOW_XTAL_PIN_A,
    output reg         INT_OSC_RUN,
    output wire        INT_OSC_AVAIL,
    output reg         XTAL_OSC_RUN,
    output wire        XTAL_OSC_AVAIL,
    output reg         XTAL_EXT_CLOCK,
    output reg         XTAL_LOW_POWER,
    output reg         XTAL_PIN_OVERRIDE
);

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    reg        int_keep_run_q;
    reg        xt_keep_run_q;
    reg [1:0]  crystal_startup_time_q;
    reg        xt_sel_q;
    reg        crystal_low_power_q;
    reg        xt_enable_q;
    reg        slow_crystal_stable_q;
    reg        slow_crystal_stable_d;
    reg        int_stable_q;
    reg [16:0] su_cnt_q;
    reg [16:0] su_cnt_d;
    reg        pin_prev_q;
    reg        int_prev_q;
    wire [7:0] int_rst_val = `INT_OSC_CTRL_RST;
    wire [7:0] xt_rst_val  = `XTAL_CTRL_RST;

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    wire        setup_phase;
    wire        wr_strobe;
    wire        hit_int;
    wire        hit_xtal;
    wire        hit_stat;
    wire        hit_any;
    wire        cfg_locked;
    reg  [31:0] rd_word;

    assign setup_phase = PSEL & ~PENABLE;
    assign wr_strobe   = PSEL & PENABLE & PREADY & PWRITE;
    assign hit_int     = (PADDR == `INT_OSC_CTRL_OFS);
    assign hit_xtal    = (PADDR == `XTAL_CTRL_OFS);
    assign hit_stat    = (PADDR == `OSC_STATUS_OFS);
    assign hit_any     = hit_int | hit_xtal | hit_stat;
    assign cfg_locked  = xt_enable_q | slow_crystal_stable_q;

    // ----------------------------------------------------------------
    // Read mux
    // ----------------------------------------------------------------
    always @* begin
        rd_word = 32'h00000000;
        if (hit_int) begin
            rd_word[`KEEP_RUN_BIT] = int_keep_run_q;
        end else if (hit_xtal) begin
            rd_word[`KEEP_RUN_BIT]                    = xt_keep_run_q;
            rd_word[`STARTUP_HI_BIT:`STARTUP_LO_BIT]  = crystal_startup_time_q;
            rd_word[`SOURCE_SEL_BIT]                  = xt_sel_q;
            rd_word[`LOW_POWER_BIT]                   = crystal_low_power_q;
            rd_word[`ENABLE_BIT]                      = xt_enable_q;
        end else if (hit_stat) begin
            rd_word[`STAT_XTAL_STABLE_BIT] = slow_crystal_stable_q;
            rd_word[`STAT_INT_STABLE_BIT]  = int_stable_q;
        end
    end

    // ----------------------------------------------------------------
    // APB answer: one wait-free access after setup
    // ----------------------------------------------------------------
    always @(posedge CLK) begin
        if (RESET) begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= 32'h00000000;
        end else begin
            PREADY  <= setup_phase;
            PSLVERR <= setup_phase & ~hit_any;
            if (setup_phase && !PWRITE) begin
                PRDATA <= rd_word;
            end else if (!PSEL) begin
                PRDATA <= 32'h00000000;
            end
        end
    end

    // ----------------------------------------------------------------
    // Control register writes
    // ----------------------------------------------------------------
    always @(posedge CLK) begin
        if (RESET) begin
            int_keep_run_q         <= int_rst_val[`KEEP_RUN_BIT];
            xt_keep_run_q          <= xt_rst_val[`KEEP_RUN_BIT];
            crystal_startup_time_q <= xt_rst_val[`STARTUP_HI_BIT:`STARTUP_LO_BIT];
            xt_sel_q               <= xt_rst_val[`SOURCE_SEL_BIT];
            crystal_low_power_q    <= xt_rst_val[`LOW_POWER_BIT];
            xt_enable_q            <= xt_rst_val[`ENABLE_BIT];
        end else if (wr_strobe) begin
            if (hit_int) begin
                int_keep_run_q <= PWDATA[`KEEP_RUN_BIT];
            end
            if (hit_xtal) begin
                xt_keep_run_q       <= PWDATA[`KEEP_RUN_BIT];
                crystal_low_power_q <= PWDATA[`LOW_POWER_BIT];
                xt_enable_q         <= PWDATA[`ENABLE_BIT];
                if (!cfg_locked) begin
                    crystal_startup_time_q <= PWDATA[`STARTUP_HI_BIT:`STARTUP_LO_BIT];
                    xt_sel_q               <= PWDATA[`SOURCE_SEL_BIT];
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Run policy
    // ----------------------------------------------------------------
    wire int_run_d;
    wire awake;
    wire xt_run_d;

    assign int_run_d = int_keep_run_q | INT_OSC_REQ;
    assign awake     = (SLEEP_MODE == `MODE_ACTIVE) | (SLEEP_MODE == `MODE_IDLE);
    assign xt_run_d  = xt_enable_q & (xt_keep_run_q | (XTAL_OSC_REQ & awake));

    always @(posedge CLK) begin
        if (RESET) begin
            INT_OSC_RUN       <= 1'b0;
            XTAL_OSC_RUN      <= 1'b0;
            XTAL_EXT_CLOCK    <= 1'b0;
            XTAL_LOW_POWER    <= 1'b0;
            XTAL_PIN_OVERRIDE <= 1'b0;
        end else begin
            INT_OSC_RUN       <= int_run_d;
            XTAL_OSC_RUN      <= xt_run_d;
            XTAL_EXT_CLOCK    <= xt_sel_q;
            XTAL_LOW_POWER    <= crystal_low_power_q;
            XTAL_PIN_OVERRIDE <= xt_enable_q;
        end
    end

    // ----------------------------------------------------------------
    // Crystal start-up counter
    // ----------------------------------------------------------------
    reg  [16:0] su_target;
    wire        pin_rise;

    assign pin_rise = SLOW_XTAL_PIN_A & ~pin_prev_q;

    always @* begin
        case (crystal_startup_time_q)
            2'h0:    su_target = SU_COUNT_0;
            2'h1:    su_target = SU_COUNT_1;
            2'h2:    su_target = SU_COUNT_2;
            2'h3:    su_target = SU_COUNT_3;
            default: su_target = SU_COUNT_0;
        endcase
        if (xt_sel_q) begin
            su_target = `EXT_CLK_RUN_EDGES;
        end
    end

    always @* begin
        su_cnt_d              = su_cnt_q;
        slow_crystal_stable_d = slow_crystal_stable_q;
        if (!xt_enable_q) begin
            su_cnt_d              = 17'h00000;
            slow_crystal_stable_d = 1'b0;
        end else if (XTAL_OSC_RUN && pin_rise && !slow_crystal_stable_q) begin
            su_cnt_d = su_cnt_q + 17'h00001;
            if (su_cnt_q + 17'h00001 >= su_target) begin
                slow_crystal_stable_d = 1'b1;
            end
        end
    end

    always @(posedge CLK) begin
        if (RESET) begin
            su_cnt_q              <= 17'h00000;
            slow_crystal_stable_q <= 1'b0;
            pin_prev_q            <= 1'b0;
            int_prev_q            <= 1'b0;
            int_stable_q          <= 1'b0;
        end else begin
            su_cnt_q              <= su_cnt_d;
            slow_crystal_stable_q <= slow_crystal_stable_d;
            pin_prev_q            <= SLOW_XTAL_PIN_A;
            int_prev_q            <= INT_OSC_LEVEL;
            if (!INT_OSC_RUN) begin
                int_stable_q <= 1'b0;
            end else if (INT_OSC_LEVEL && !int_prev_q) begin
                int_stable_q <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Availability to consumers
    // ----------------------------------------------------------------
    osc_avail_gate #(
        .EDGES     (`INT_AVAIL_EDGES)
    ) u_int_gate (
        .clk       (CLK),
        .reset     (RESET),
        .osc_level (INT_OSC_LEVEL),
        .open_req  (INT_OSC_REQ & INT_OSC_RUN),
        .avail_q   (INT_OSC_AVAIL)
    );

    osc_avail_gate #(
        .EDGES     (`XTAL_AVAIL_EDGES)
    ) u_xtal_gate (
        .clk       (CLK),
        .reset     (RESET),
        .osc_level (SLOW_XTAL_PIN_A),
        .open_req  (XTAL_OSC_REQ & XTAL_OSC_RUN & slow_crystal_stable_q),
        .avail_q   (XTAL_OSC_AVAIL)
    );

endmodule // slow_oscillator_control

// file: rtl/slow_osc_defines.vh
// Constants for the slow oscillator control block
`ifndef SLOW_OSC_DEFINES_VH
`define SLOW_OSC_DEFINES_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define INT_OSC_CTRL_OFS      8'h18
`define XTAL_CTRL_OFS         8'h1C
`define OSC_STATUS_OFS        8'h28

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define KEEP_RUN_BIT          7
`define STARTUP_HI_BIT        5
`define STARTUP_LO_BIT        4
`define SOURCE_SEL_BIT        2
`define LOW_POWER_BIT         1
`define ENABLE_BIT            0
`define STAT_XTAL_STABLE_BIT  4
`define STAT_INT_STABLE_BIT   2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define INT_OSC_CTRL_RST      8'h00
`define XTAL_CTRL_RST         8'h00

// ----------------------------------------------------------------
// Sleep mode codes
// ----------------------------------------------------------------
`define MODE_ACTIVE           2'h0
`define MODE_IDLE             2'h1
`define MODE_STANDBY          2'h2
`define MODE_POWER_DOWN       2'h3

// ----------------------------------------------------------------
// Timing counts in oscillator cycles
// ----------------------------------------------------------------
`define INT_AVAIL_EDGES       3'h4
`define XTAL_AVAIL_EDGES      3'h3
`define XTAL_SU_1K            17'h00400
`define XTAL_SU_16K           17'h04000
`define XTAL_SU_32K           17'h08000
`define XTAL_SU_64K           17'h10000
`define EXT_CLK_RUN_EDGES     17'h00004

`endif

// file: rtl/osc_avail_gate.v
// Availability gate: passes an oscillator to a requester after N oscillator cycles
`timescale 1ns/1ns
module osc_avail_gate #(
    parameter [2:0] EDGES = 3'h4
) (
    input  wire clk,
    input  wire reset,
    input  wire osc_level,
    input  wire open_req,
    output reg  avail_q
);

    // ----------------------------------------------------------------
    // Edge detect on the sampled oscillator
    // ----------------------------------------------------------------
    reg       osc_prev_q;
    reg [2:0] edge_cnt_q;
    reg [2:0] edge_cnt_d;
    reg       avail_d;
    wire      osc_rise;

    assign osc_rise = osc_level & ~osc_prev_q;

    // ----------------------------------------------------------------
    // Cycle counter
    // ----------------------------------------------------------------
    always @* begin
        edge_cnt_d = edge_cnt_q;
        avail_d    = avail_q;
        if (!open_req) begin
            edge_cnt_d = 3'h0;
            avail_d    = 1'b0;
        end else if (osc_rise && !avail_q) begin
            edge_cnt_d = edge_cnt_q + 3'h1;
            if (edge_cnt_q + 3'h1 >= EDGES) begin
                avail_d = 1'b1;
            end
        end
    end

    always @(posedge clk) begin
        if (reset) begin
            osc_prev_q <= 1'b0;
            edge_cnt_q <= 3'h0;
            avail_q    <= 1'b0;
        end else begin
            osc_prev_q <= osc_level;
            edge_cnt_q <= edge_cnt_d;
            avail_q    <= avail_d;
        end
    end

endmodule // osc_avail_gate

// file: tb/slow_osc_checker_assertions.sv
// Checker for the slow oscillator control block
`timescale 1ns/1ns
`include "slow_osc_defines.vh"
module slow_osc_checker (
    input wire        CLK,
    input wire        RESET,
    input wire        PSEL,
    input wire        PENABLE,
    input wire        PWRITE,
    input wire [7:0]  PADDR,
    input wire [31:0] PWDATA,
    input wire [31:0] PRDATA,
    input wire        PREADY,
    input wire [1:0]  SLEEP_MODE,
    input wire        INT_OSC_REQ,
    input wire        XTAL_OSC_REQ,
    input wire        INT_OSC_RUN,
    input wire        INT_OSC_AVAIL,
    input wire        XTAL_OSC_RUN,
    input wire        XTAL_OSC_AVAIL,
    input wire        XTAL_EXT_CLOCK,
    input wire        XTAL_LOW_POWER,
    input wire        XTAL_PIN_OVERRIDE
);
    // ------------------------------------------------------------
    // Shadow keep-running bits and crystal enable bit
    // ------------------------------------------------------------
    reg  keep_i_q;
    reg  keep_x_q;
    reg  en_x_q;
    wire wr = PSEL && PENABLE && PREADY && PWRITE;
    wire wx = wr && PADDR == `XTAL_CTRL_OFS;
    always @(posedge CLK) begin
        if (RESET) begin
            keep_i_q <= 1'b0;
            keep_x_q <= 1'b0;
            en_x_q   <= 1'b0;
        end else if (wr && PADDR == `INT_OSC_CTRL_OFS) begin
            keep_i_q <= PWDATA[7];
        end else if (wx) begin
            keep_x_q <= PWDATA[7];
            en_x_q   <= PWDATA[0];
        end
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);
    property p_int_run;
        INT_OSC_RUN == ($past(keep_i_q) || $past(INT_OSC_REQ));
    endproperty
    a_int_run: assert property (p_int_run)
        else $error("internal run wrong");
    property p_xtal_run;
        XTAL_OSC_RUN == ($past(en_x_q) && ($past(keep_x_q)
            || ($past(XTAL_OSC_REQ) && $past(SLEEP_MODE) < 2'h2)));
    endproperty
    a_xtal_run: assert property (p_xtal_run)
        else $error("crystal run wrong");
    property p_int_avail_req;
        INT_OSC_AVAIL |-> $past(INT_OSC_REQ);
    endproperty
    a_int_avail_req: assert property (p_int_avail_req)
        else $error("internal delivered without request");
    property p_int_avail_delay;
        $rose(INT_OSC_REQ) |=> !INT_OSC_AVAIL [*6];
    endproperty
    a_int_avail_delay: assert property (p_int_avail_delay)
        else $error("internal delivered too early");
    property p_xtal_avail_req;
        XTAL_OSC_AVAIL |-> $past(XTAL_OSC_REQ);
    endproperty
    a_xtal_avail_req: assert property (p_xtal_avail_req)
        else $error("crystal delivered without request");
    property p_low_power;
        wx |-> ##2 XTAL_LOW_POWER == $past(PWDATA[1], 2);
    endproperty
    a_low_power: assert property (p_low_power)
        else $error("low power bit wrong");
    property p_sel_lock;
        wx && XTAL_PIN_OVERRIDE |-> ##2 $stable(XTAL_EXT_CLOCK);
    endproperty
    a_sel_lock: assert property (p_sel_lock)
        else $error("source select changed while locked");
    property p_sel_free;
        wx && !XTAL_PIN_OVERRIDE |-> ##2 XTAL_EXT_CLOCK == $past(PWDATA[2], 2);
    endproperty
    a_sel_free: assert property (p_sel_free)
        else $error("source select not written");
    property p_unused_zero;
        PSEL && PENABLE && PREADY && !PWRITE && PADDR == `XTAL_CTRL_OFS
            |-> (PRDATA & 32'hFFFFFF48) == 32'h0;
    endproperty
    a_unused_zero: assert property (p_unused_zero)
        else $error("unused bits read nonzero");
    c_int_avail: cover property (INT_OSC_AVAIL);
    c_xtal_avail: cover property (XTAL_OSC_AVAIL);
    c_lock_write: cover property (wx && XTAL_PIN_OVERRIDE);
endmodule // slow_osc_checker

bind slow_oscillator_control slow_osc_checker chk_u (
    .CLK(CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .SLEEP_MODE(SLEEP_MODE), .INT_OSC_REQ(INT_OSC_REQ), .XTAL_OSC_REQ(XTAL_OSC_REQ),
    .INT_OSC_RUN(INT_OSC_RUN), .INT_OSC_AVAIL(INT_OSC_AVAIL),
    .XTAL_OSC_RUN(XTAL_OSC_RUN), .XTAL_OSC_AVAIL(XTAL_OSC_AVAIL),
    .XTAL_EXT_CLOCK(XTAL_EXT_CLOCK), .XTAL_LOW_POWER(XTAL_LOW_POWER),
    .XTAL_PIN_OVERRIDE(XTAL_PIN_OVERRIDE));

// file: tb/slow_osc_src.sv
// Slow oscillator source that toggles only while told to run
`timescale 1ns/1ns
module slow_osc_src #(
    parameter HALF = 1
) (
    input  wire clk,
    input  wire run,
    output reg  osc
);
    integer n = 0;
    initial osc = 1'b0;
    always @(posedge clk) begin
        if (!run) begin
            osc <= 1'b0;
            n   <= 0;
        end else if (n >= HALF - 1) begin
            osc <= ~osc;
            n   <= 0;
        end else begin
            n   <= n + 1;
        end
    end
endmodule // slow_osc_src

// file: tb/tb.sv
// Self-checking bench for the slow oscillator control block
`timescale 1ns/1ns
`include "slow_osc_defines.vh"
module tb;
    reg         CLK, RESET, PSEL, PENABLE, PWRITE, INT_OSC_REQ, XTAL_OSC_REQ, probe, pm;
    reg  [7:0]  PADDR, v;
    reg  [31:0] PWDATA;
    reg  [1:0]  SLEEP_MODE;
    wire [31:0] PRDATA;
    wire        PREADY, PSLVERR, INT_OSC_LEVEL, SLOW_XTAL_PIN_A, INT_OSC_RUN, INT_OSC_AVAIL;
    wire        XTAL_OSC_RUN, XTAL_OSC_AVAIL, XTAL_EXT_CLOCK, XTAL_LOW_POWER, XTAL_PIN_OVERRIDE;
    reg  [32:0] q[$];
    reg  [32:0] got;
    integer     n_fail, comparisons, cyc, i, k, m;
    slow_oscillator_control #(.SU_COUNT_0(17'h4), .SU_COUNT_1(17'h8), .SU_COUNT_2(17'hC),
        .SU_COUNT_3(17'h10)) dut_u (.CLK(CLK), .RESET(RESET), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
        .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .SLEEP_MODE(SLEEP_MODE),
        .INT_OSC_REQ(INT_OSC_REQ), .INT_OSC_LEVEL(INT_OSC_LEVEL),
        .XTAL_OSC_REQ(XTAL_OSC_REQ), .SLOW_XTAL_PIN_A(SLOW_XTAL_PIN_A),
        .INT_OSC_RUN(INT_OSC_RUN), .INT_OSC_AVAIL(INT_OSC_AVAIL),
        .XTAL_OSC_RUN(XTAL_OSC_RUN), .XTAL_OSC_AVAIL(XTAL_OSC_AVAIL),
        .XTAL_EXT_CLOCK(XTAL_EXT_CLOCK), .XTAL_LOW_POWER(XTAL_LOW_POWER),
        .XTAL_PIN_OVERRIDE(XTAL_PIN_OVERRIDE));
    slow_osc_src int_src_u (.clk(CLK), .run(INT_OSC_RUN), .osc(INT_OSC_LEVEL));
    slow_osc_src #(.HALF(3)) xtal_src_u (.clk(CLK), .run(XTAL_OSC_RUN), .osc(SLOW_XTAL_PIN_A));
    initial begin
        CLK = 1'b0;
        forever #25 CLK = ~CLK;
    end
    // ------------------------------------------------------------
    // Compare, verdict and bus tasks
    // ------------------------------------------------------------
    task cmp(input [32:0] g, input [32:0] e);
        begin
            comparisons = comparisons + 1;
            if (g !== e) begin
                n_fail = n_fail + 1;
                $display("mismatch at %0t: got %h expected %h", $time, g, e);
            end
        end
    endtask
    task give_verdict;
        begin
            $display("comparisons %0d n_fail %0d", comparisons, n_fail);
            if (n_fail == 0 && comparisons > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask
    task apb(input w, input [7:0] a, input [31:0] d, input [32:0] e);
        begin
            @(posedge CLK);
            PSEL <= 1'b1;
            PWRITE <= w;
            PADDR <= a;
            PWDATA <= d;
            if (!w) q.push_back(e);
            @(posedge CLK);
            PENABLE <= 1'b1;
            @(posedge CLK);
            while (PREADY !== 1'b1) @(posedge CLK);
            PSEL <= 1'b0;
            PENABLE <= 1'b0;
        end
    endtask
    task probe_chk(input [32:0] e);
        begin
            @(posedge CLK);
            q.push_back(e);
            probe <= 1'b1;
            @(posedge CLK);
            probe <= 1'b0;
        end
    endtask
    task count_chk(input x, input integer lo, input integer hi);
        integer c;
        reg     p;
        begin
            c = 0;
            p = 1'b0;
            while ((x ? XTAL_OSC_AVAIL : INT_OSC_AVAIL) !== 1'b1) begin
                @(posedge CLK);
                if ((x ? SLOW_XTAL_PIN_A : INT_OSC_LEVEL) && !p) c = c + 1;
                p = x ? SLOW_XTAL_PIN_A : INT_OSC_LEVEL;
            end
            cmp(33'((c >= lo && c <= hi) ? lo : c), 33'(lo));
        end
    endtask
    // ------------------------------------------------------------
    // Result monitor
    // ------------------------------------------------------------
    always @(posedge CLK) begin
        if ((PSEL && PENABLE && PREADY && !PWRITE) || probe) begin
            got = probe ? {26'h0, XTAL_OSC_RUN, INT_OSC_RUN, XTAL_OSC_AVAIL & pm,
                INT_OSC_AVAIL & pm, XTAL_EXT_CLOCK, XTAL_LOW_POWER, XTAL_PIN_OVERRIDE}
                : {PSLVERR, PRDATA};
            if (q.size() == 0) cmp(got, ~got);
            else cmp(got, q.pop_front());
        end
    end
    always @(posedge CLK) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            n_fail = n_fail + 1;
            give_verdict;
        end
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {PSEL, PENABLE, PWRITE, INT_OSC_REQ, XTAL_OSC_REQ, probe, pm} = 7'h0;
        {PADDR, PWDATA, SLEEP_MODE} = 42'h0;
        {n_fail, comparisons, cyc} = 96'h0;
        RESET = 1'b1;
        m = $urandom(40);
        repeat (2) @(posedge CLK);
        RESET <= 1'b0;
        apb(0, `XTAL_CTRL_OFS, 32'h0, 33'h0);
        apb(0, `INT_OSC_CTRL_OFS, 32'h0, 33'h0);
        apb(0, 8'h40, 32'h0, {1'b1, 32'h0});
        apb(1, `XTAL_CTRL_OFS, 32'hFE, 33'h0);
        apb(0, `XTAL_CTRL_OFS, 32'h0, 33'hB6);
        probe_chk(33'h06);
        apb(1, `XTAL_CTRL_OFS, 32'h01, 33'h0);
        apb(1, `XTAL_CTRL_OFS, 32'h35, 33'h0);
        apb(0, `XTAL_CTRL_OFS, 32'h0, 33'h01);
        for (k = 0; k < 2; k = k + 1) begin
            apb(1, `INT_OSC_CTRL_OFS, k << 7, 33'h0);
            apb(1, `XTAL_CTRL_OFS, (k << 7) | 1, 33'h0);
            for (i = 0; i < 10; i = i + 1) begin
                m = $urandom % 4;
                v = 8'($urandom);
                SLEEP_MODE <= m[1:0];
                INT_OSC_REQ <= v[0];
                XTAL_OSC_REQ <= v[1];
                probe_chk({26'h0, k[0] | (v[1] & (m < 2)), k[0] | v[0], 5'h01});
            end
        end
        apb(1, `INT_OSC_CTRL_OFS, 32'h0, 33'h0);
        apb(1, `XTAL_CTRL_OFS, 32'h0, 33'h0);
        {SLEEP_MODE, INT_OSC_REQ, XTAL_OSC_REQ} <= 4'h0;
        pm <= 1'b1;
        repeat (3) @(posedge CLK);
        INT_OSC_REQ <= 1'b1;
        count_chk(0, 4, 5);
        INT_OSC_REQ <= 1'b0;
        repeat (2) @(posedge CLK);
        probe_chk(33'h0);
        for (i = 0; i < 5; i = i + 1) begin
            v = (i < 4) ? i << 4 : 8'h04;
            apb(1, `XTAL_CTRL_OFS, {24'h0, v}, 33'h0);
            apb(1, `XTAL_CTRL_OFS, {24'h0, v | 8'h01}, 33'h0);
            XTAL_OSC_REQ <= 1'b1;
            m = (i < 4) ? 4 * (i + 1) : `EXT_CLK_RUN_EDGES;
            count_chk(1, m + 1, m + 4);
            apb(1, `XTAL_CTRL_OFS, {24'h0, (v ^ 8'h34) | 8'h01}, 33'h0);
            apb(0, `XTAL_CTRL_OFS, 32'h0, {25'h0, v | 8'h01});
            XTAL_OSC_REQ <= 1'b0;
            apb(1, `XTAL_CTRL_OFS, 32'h0, 33'h0);
        end
        give_verdict;
    end
endmodule // tb
